// ### verilog/cgc_can_general_control.v
// CAN global control register with its AXI4-Lite slave and control outputs
// What this block does
// - Eight-bit read/write global control register at 0xD8, reset to zero.
// - Abort request clears both enable registers; transfer in progress completes.
// - Abort leaves page control alone; abort bit stays until software clears.
// - Overload request sends overload frame after next received frame; not self-clearing.
// - Overload frame sending is visible through the status overload flag.
// - Time-triggered bit selects time-triggered mode; zero is event-driven.
// - Capture select: zero captures on start of frame, one on last end bit.
// - Capture select is ignored unless time-triggered mode is active.
// - Listening bit places controller in listening mode.
// - Enable entered only after eleven recessive bits; status flag shows true state.
// - Standby finishes transmission, freezes objects, drives recessive, disables receiver.
// - Soft reset bit self-clears, resets controller only, ORed with hardware reset.
// - Overload status flag high while produced overload frame is sent, no interrupt.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "cgc_map.vh"
module cgc_can_general_control (
  input  wire        aclk,              // 40 MHz clock
  input  wire        aresetn,           // Sync reset, active low
  input  wire        clk_en,            // Freezes all state when low, except that hardware reset still acts and ctrl_reset still clears the enable flag and run counter
  input  wire [7:0]  s_axi_awaddr,      // Write address
  input  wire        s_axi_awvalid,     // Write address valid
  output reg         s_axi_awready,     // Write address ready
  input  wire [31:0] s_axi_wdata,       // Write data
  input  wire [3:0]  s_axi_wstrb,       // Write strobes
  input  wire        s_axi_wvalid,      // Write data valid
  output reg         s_axi_wready,      // Write data ready
  output reg  [1:0]  s_axi_bresp,       // Write response
  output reg         s_axi_bvalid,      // Write response valid
  input  wire        s_axi_bready,      // Write response ready
  input  wire [7:0]  s_axi_araddr,      // Read address
  input  wire        s_axi_arvalid,     // Read address valid
  output reg         s_axi_arready,     // Read address ready
  output reg  [31:0] s_axi_rdata,       // Read data
  output reg  [1:0]  s_axi_rresp,       // Read response
  output reg         s_axi_rvalid,      // Read response valid
  input  wire        s_axi_rready,      // Read response ready
  input  wire        can_rx_pin,        // Bus level from transceiver, 1 recessive
  input  wire        bit_tick,          // One pulse per sampled bus bit time
  input  wire        frame_rx_done,     // Pulse: a frame was received
  input  wire        tx_active,         // Engine transmitting a frame
  input  wire        ovl_sending,       // Engine sending an overload frame
  output reg         can_tx_pin,        // Bus drive, 1 recessive
  output reg         mob_enable_clear,  // Clear both object enable registers
  output reg         ovl_frame_req,     // Ask engine for overload frame
  output reg         time_triggered_mode, // Time-triggered mode active
  output reg         capture_on_eof,    // Timer captured on last end bit
  output reg         listen_mode,       // Listening mode active
  output reg         test_mode,         // Factory test mode
  output reg         standby,           // Objects frozen, receiver off
  output reg         ctrl_reset,        // Controller reset, soft OR hard
  input  wire        engine_tx_bit      // Engine's wanted bus bit, 1 recessive
);

  reg [7:0] gcon_q;
  reg       en_flag_q;
  reg       ovl_stat_q;
  reg [3:0] rec_cnt_q;
  reg       rx_s1_q;
  reg       rx_s2_q;
  reg       aw_hold_q;
  reg       w_hold_q;
  reg [7:0] awaddr_q;
  reg [7:0] wbyte_q;
  reg       wstrb_q;
  // Decode and status word: overload status at bit 6, enable flag at bit 2
  wire      hw_rst = ~aresetn;
  wire      wr_go  = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire      wr_hit = awaddr_q == `CGC_GCON_OFFSET;
  wire      rd_hit = (s_axi_araddr == `CGC_GCON_OFFSET) | (s_axi_araddr == `CGC_GSTA_OFFSET);
  wire [7:0] sta_val = {1'b0, ovl_stat_q, 3'b000, en_flag_q, 2'b00};

  // Last count of the recessive run, cut to the counter width on purpose
  localparam integer REC_LAST_I = `CGC_RECESSIVE_RUN - 1;
  localparam [3:0]   REC_LAST   = REC_LAST_I[3:0];

  // Bus pin passes two flops before use
  always @(posedge aclk) begin
    if (hw_rst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else if (clk_en) begin
      rx_s1_q <= can_rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (hw_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wbyte_q       <= 8'h00;
      wstrb_q       <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CGC_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q     <= 1'b1;
        wbyte_q      <= s_axi_wdata[7:0];
        wstrb_q      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      // Response only after both halves; a bad address answers SLVERR, no write
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `CGC_RESP_OKAY : `CGC_RESP_SLVERR;
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
      end
      // Readys return only once the response is taken: one write at a time
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control register; soft reset bit stays set one cycle after its write, then clears itself
  always @(posedge aclk) begin
    if (hw_rst) begin
      gcon_q <= `CGC_GCON_RESET;
    end else if (clk_en) begin
      // Only byte lane 0 carries the register; other lanes are ignored
      if (wr_go && wr_hit && wstrb_q) begin
        gcon_q <= wbyte_q;
      end else begin
        gcon_q[`CGC_BIT_SOFT_RST] <= 1'b0;
      end
    end
  end

  // Read channel, one cycle from address to data
  always @(posedge aclk) begin
    if (hw_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CGC_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= rd_hit ? `CGC_RESP_OKAY : `CGC_RESP_SLVERR;
        if (s_axi_araddr == `CGC_GCON_OFFSET)
          s_axi_rdata <= {24'h00_0000, gcon_q};
        else if (s_axi_araddr == `CGC_GSTA_OFFSET)
          s_axi_rdata <= {24'h00_0000, sta_val};
        else
          s_axi_rdata <= 32'h0000_0000;
      // Address channel held off until the read data is taken
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Enable only after a run of recessive bits; counter clears while the enable bit is off
  always @(posedge aclk) begin
    if (hw_rst || ctrl_reset) begin
      en_flag_q <= 1'b0;
      rec_cnt_q <= 4'h0;
    end else if (clk_en) begin
      if (!gcon_q[`CGC_BIT_ENABLE]) begin
        if (!tx_active) begin
          en_flag_q <= 1'b0;
        end
        rec_cnt_q <= 4'h0;
      end else if (!en_flag_q && bit_tick) begin
        // A dominant bit restarts the run
        if (!rx_s2_q) begin
          rec_cnt_q <= 4'h0;
        end else if (rec_cnt_q == REC_LAST) begin
          en_flag_q <= 1'b1;
        end else begin
          rec_cnt_q <= rec_cnt_q + 4'h1;
        end
      end
    end
  end

  // Control outputs straight from flops
  always @(posedge aclk) begin
    if (hw_rst) begin
      ovl_stat_q          <= 1'b0;
      can_tx_pin          <= 1'b1;
      mob_enable_clear    <= 1'b0;
      ovl_frame_req       <= 1'b0;
      time_triggered_mode <= 1'b0;
      capture_on_eof      <= 1'b0;
      listen_mode         <= 1'b0;
      test_mode           <= 1'b0;
      standby             <= 1'b1;
      ctrl_reset          <= 1'b1;
    end else if (clk_en) begin
      ctrl_reset          <= gcon_q[`CGC_BIT_SOFT_RST];
      // Status copy lags the engine by one cycle
      ovl_stat_q          <= ovl_sending;
      mob_enable_clear    <= gcon_q[`CGC_BIT_ABORT];
      // Engine latches after next received frame, so a level is enough
      ovl_frame_req       <= gcon_q[`CGC_BIT_OVL_REQ];
      time_triggered_mode <= gcon_q[`CGC_BIT_TTM];
      capture_on_eof      <= gcon_q[`CGC_BIT_TTM] & gcon_q[`CGC_BIT_CAPSEL];
      listen_mode         <= gcon_q[`CGC_BIT_LISTEN];
      test_mode           <= gcon_q[`CGC_BIT_TEST];
      standby             <= ~en_flag_q;
      // Dominant only when enabled and not listening
      can_tx_pin          <= engine_tx_bit | ~en_flag_q | gcon_q[`CGC_BIT_LISTEN];
    end
  end

endmodule

// ### shared/cgc_map.vh
// Register map and field positions of the CAN global control block
`ifndef CGC_MAP_VH
`define CGC_MAP_VH
`define CGC_GCON_OFFSET     8'hD8
`define CGC_GSTA_OFFSET     8'hDC
`define CGC_GCON_RESET      8'h00
`define CGC_BIT_SOFT_RST    0
`define CGC_BIT_ENABLE      1
`define CGC_BIT_TEST        2
`define CGC_BIT_LISTEN      3
`define CGC_BIT_CAPSEL      4
`define CGC_BIT_TTM         5
`define CGC_BIT_OVL_REQ     6
`define CGC_BIT_ABORT       7
`define CGC_STA_OVL_STAT    6
`define CGC_STA_EN_FLAG     2
`define CGC_RECESSIVE_RUN   11
`define CGC_RESP_OKAY       2'b00
`define CGC_RESP_SLVERR     2'b10
`endif

// ### sim/cgc_gc_sva.sv
// Port assertions for the CAN global control block
`timescale 1ns/1ps
module cgc_gc_sva (
  input wire aclk,                // Clock
  input wire aresetn,             // Reset, low
  input wire s_axi_wvalid,        // Write data valid
  input wire can_tx_pin,          // Bus drive
  input wire mob_enable_clear,    // Abort out
  input wire ovl_frame_req,       // Overload out
  input wire time_triggered_mode, // Time mode
  input wire capture_on_eof,      // Capture point
  input wire listen_mode,         // Listen mode
  input wire standby,             // Standby
  input wire ctrl_reset           // Soft reset
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Control bits only move shortly after a write; hardware never clears them
  property p_ab; (!s_axi_wvalid)[*5] |-> $stable(mob_enable_clear); endproperty
  a_ab: assert property (p_ab) else $error("abort moved");
  property p_ov; (!s_axi_wvalid)[*5] |-> $stable(ovl_frame_req); endproperty
  a_ov: assert property (p_ov) else $error("overload moved");
  property p_tt; (!s_axi_wvalid)[*5] |-> $stable(time_triggered_mode); endproperty
  a_tt: assert property (p_tt) else $error("time mode moved");
  property p_ls; (!s_axi_wvalid)[*5] |-> $stable(listen_mode); endproperty
  a_ls: assert property (p_ls) else $error("listen moved");
  // Capture point means nothing outside time mode
  property p_cp; capture_on_eof |-> time_triggered_mode; endproperty
  a_cp: assert property (p_cp) else $error("capture without mode");
  // One cycle of slack for the mode to reach the driver
  property p_lq; listen_mode && $past(listen_mode) |-> can_tx_pin; endproperty
  a_lq: assert property (p_lq) else $error("dominant in listen");
  property p_sb; standby && $past(standby) |-> can_tx_pin; endproperty
  a_sb: assert property (p_sb) else $error("dominant in standby");
  property p_sr; $rose(ctrl_reset) |=> !ctrl_reset; endproperty
  a_sr: assert property (p_sr) else $error("soft reset stuck");
endmodule

// ### sim/cgc_bus_node.sv
// Other CAN nodes on a wired-AND bus
`timescale 1ns/1ps
module cgc_bus_node (
  input  wire aclk,       // Clock
  input  wire busy,       // Nodes sending
  input  wire dut_tx,     // Block drive
  output wire can_rx_pin, // Bus level
  output wire bit_tick    // Bit pulse
);
  reg [2:0] ph_q = 3'h0; // Bit phase
  reg       nd_q = 1'b1; // Node level
  assign can_rx_pin = dut_tx & nd_q;
  assign bit_tick = (ph_q == 3'h0);
  // Level moves mid-bit so each tick sees it settled
  always @(posedge aclk) begin
    ph_q <= ph_q + 3'h1;
    if (ph_q == 3'h4) nd_q <= busy ? ~nd_q : 1'b1;
  end
endmodule

// ### sim/cgc_can_general_control_tb_top.sv
// Self-checking bench for the CAN global control block
`timescale 1ns/1ps
`include "cgc_map.vh"
module cgc_can_general_control_tb_top;
  localparam [7:0] gc = `CGC_GCON_OFFSET;
  reg         aclk, aresetn, ce, awv, wv, bre, arv, rre, busy, etx, tact, ovs, frd;
  reg  [7:0]  awa, ara;
  reg  [31:0] wd;
  reg  [3:0]  wst;
  wire        awr, wrd, bv, arr, rv, tx, abt, ovq, ttm, cap, lis, tm, stb, crs, rx, tk;
  wire [1:0]  br, rr;
  wire [31:0] rd;
  integer     err_total, tests_run, i;
  // Block with the other nodes on its pins
  cgc_can_general_control dut (.aclk(aclk), .aresetn(aresetn), .clk_en(ce),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(wst), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .can_rx_pin(rx), .bit_tick(tk), .frame_rx_done(frd),
    .tx_active(tact), .ovl_sending(ovs), .can_tx_pin(tx), .mob_enable_clear(abt),
    .ovl_frame_req(ovq), .time_triggered_mode(ttm), .capture_on_eof(cap), .listen_mode(lis),
    .test_mode(tm), .standby(stb), .ctrl_reset(crs), .engine_tx_bit(etx));
  cgc_bus_node u_node (.aclk(aclk), .busy(busy), .dut_tx(tx), .can_rx_pin(rx), .bit_tick(tk));
  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One access: request and ready raised together, each held until taken;
  // the answer is captured at the edge it is seen, then all is released
  task bus(input w, input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] e);
    reg        done;
    reg [31:0] got_d;
    reg [1:0]  got_e;
    done  = 1'b0;
    got_d = 32'h0000_0000;
    got_e = 2'b00;
    awa <= a;
    ara <= a;
    wd  <= d;
    wst <= s;
    awv <= w;
    wv  <= w;
    bre <= w;
    arv <= !w;
    rre <= !w;
    while (!done) begin
      @(posedge aclk);
      if (awr && awv) awv <= 1'b0;
      if (wrd && wv) wv <= 1'b0;
      if (arr && arv) arv <= 1'b0;
      if (w ? bv : rv) begin
        done  = 1'b1;
        got_d = rd;
        got_e = w ? br : rr;
      end
    end
    bre <= 1'b0;
    rre <= 1'b0;
    @(posedge aclk);
    if (!w) chk(got_d, d);
    chk({30'h0, got_e}, {30'h0, e});
  endtask
  task t_reset;
    chk({25'h0, crs, stb, tx, abt, ovq, ttm, lis}, 32'h70);
    bus(1'b0, gc, 32'h0, 4'h1, 2'b00);
    bus(1'b1, 8'h44, 32'hff, 4'h1, `CGC_RESP_SLVERR);
    bus(1'b0, 8'h44, 32'h0, 4'h1, `CGC_RESP_SLVERR);
    $display("reset test done");
  endtask
  // Test bit never written; upper byte lanes must not reach the register
  task t_fields;
    for (i = 3; i < 8; i = i + 1) begin
      bus(1'b1, gc, 32'h1 << i, 4'h1, 2'b00);
      repeat (20) @(posedge aclk);
      bus(1'b0, gc, 32'h1 << i, 4'h1, 2'b00);
      chk({26'h0, tm, abt, ovq, ttm, cap, lis}, (i == 4) ? 32'h0 : 32'h1 << (i - 3));
    end
    bus(1'b1, gc, 32'h30, 4'h1, 2'b00);
    chk({30'h0, ttm, cap}, 32'h3);
    bus(1'b1, gc, 32'hff, 4'he, 2'b00);
    bus(1'b0, gc, 32'h30, 4'h1, 2'b00);
    chk({29'h0, tm, ttm, cap}, 32'h3);
    $display("field test done");
  endtask
  // Overload request outlives a received frame; status follows the engine
  task t_overload;
    bus(1'b1, gc, 32'h40, 4'h1, 2'b00);
    frd <= 1'b1;
    ovs <= 1'b1;
    @(posedge aclk);
    frd <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({31'h0, ovq}, 32'h1);
    bus(1'b0, `CGC_GSTA_OFFSET, 32'h40, 4'h1, 2'b00);
    ovs <= 1'b0;
    repeat (3) @(posedge aclk);
    bus(1'b0, `CGC_GSTA_OFFSET, 32'h0, 4'h1, 2'b00);
    bus(1'b0, gc, 32'h40, 4'h1, 2'b00);
    bus(1'b1, gc, 32'h0, 4'h1, 2'b00);
    $display("overload test done");
  endtask
  // Busy bus and a frozen clock enable hold off enable; quiet bus lets it in
  task t_enable;
    busy <= 1'b1;
    bus(1'b1, gc, 32'h2, 4'h1, 2'b00);
    repeat (300) @(posedge aclk);
    chk({31'h0, stb}, 32'h1);
    busy <= 1'b0;
    etx <= 1'b0;
    ce <= 1'b0;
    repeat (200) @(posedge aclk);
    chk({30'h0, stb, tx}, 32'h3);
    ce <= 1'b1;
    repeat (200) @(posedge aclk);
    chk({30'h0, stb, tx}, 32'h0);
    bus(1'b0, `CGC_GSTA_OFFSET, 32'h4, 4'h1, 2'b00);
    bus(1'b1, gc, 32'ha, 4'h1, 2'b00);
    chk({31'h0, tx}, 32'h1);
    tact <= 1'b1;
    bus(1'b1, gc, 32'h0, 4'h1, 2'b00);
    repeat (5) @(posedge aclk);
    chk({30'h0, stb, tx}, 32'h0);
    tact <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({30'h0, stb, tx}, 32'h3);
    bus(1'b1, gc, 32'h1, 4'h1, 2'b00);
    bus(1'b0, gc, 32'h0, 4'h1, 2'b00);
    $display("mode test done");
  endtask
  // Reset in mid-run clears the register and the abort, time and listen outputs
  task t_rerun;
    bus(1'b1, gc, 32'ha8, 4'h1, 2'b00);
    chk({29'h0, abt, ttm, lis}, 32'h7);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk({25'h0, crs, stb, tx, abt, ovq, ttm, lis}, 32'h70);
    @(posedge aclk);
    @(posedge aclk);
    chk({31'h0, crs}, 32'h0);
    bus(1'b0, gc, 32'h0, 4'h1, 2'b00);
    $display("rerun test done");
  endtask
  task end_sim;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    {awv, wv, bre, arv, rre, busy, tact, ovs, frd} = 9'h0;
    {awa, ara, wd, wst} = 52'h0;
    etx = 1'b1;
    err_total = 0;
    tests_run = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_fields;
    t_overload;
    t_enable;
    t_rerun;
    end_sim;
  end
  // Hang guard, well past the expected run
  initial begin
    #100000;
    err_total = err_total + 1;
    end_sim;
  end
endmodule
bind cgc_can_general_control cgc_gc_sva u_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_wvalid(s_axi_wvalid), .can_tx_pin(can_tx_pin), .mob_enable_clear(mob_enable_clear),
  .ovl_frame_req(ovl_frame_req), .time_triggered_mode(time_triggered_mode),
  .capture_on_eof(capture_on_eof), .listen_mode(listen_mode), .standby(standby),
  .ctrl_reset(ctrl_reset));
